// ===== core/pfs_defines.svh
// Constants for the pin function select block
// Notes on behaviour
// R1 - Config bit 1 turns port A, channel B into host
// R2 - Config bits 1,2 pick host status pins
// R3 - Config bit 7 turns channel A pins to port C
// R4 - Write strobe pin: strobe, port C2 or RTS
// R5 - Mux bit 2 swaps daisy enable in/out
// R6 - Mux bit 3 swaps read/request strobe
// R7 - Port C 6,7 read interrupt pins, never drive
// R8 - Mux bit 3, then config bit 7, pick
// R9 - Reset leaves every pin at first function
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
// Register byte offsets
`define PFS_OFS_SYSCFG 8'h00
`define PFS_OFS_PINMUX 8'h04
`define PFS_OFS_STATUS 8'h08
// Field positions
`define PFS_CFG_HOST 1
`define PFS_CFG_HSTAT 2
`define PFS_CFG_PORTC 7
`define PFS_MUX_DAISY 2
`define PFS_MUX_MEMSTB 3
`define PFS_STRB_LANE 0
// Reset values
`define PFS_CFG_RST 8'h00
`define PFS_MUX_RST 8'h00
`define PFS_PC_OE_RST 6'h04
`define PFS_ZERO_HI 24'h00_0000
// Bus answers
`define PFS_RESP_OKAY 2'b00
`define PFS_RESP_SLVERR 2'b10
// Synchroniser width: all pin inputs
`define PFS_SYNC_W 27
`endif

// ===== core/pfs_pkg.sv
// Types shared by the pin function select block
package pfs_pkg;
	typedef enum logic [1:0] {pfs_idle, pfs_take, pfs_resp} pfs_bus_st_t;
	typedef enum logic [1:0] {pfs_reg_cfg, pfs_reg_mux, pfs_reg_stat, pfs_reg_none} pfs_reg_t;
endpackage

// ===== core/pfs_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module pfs_sync #(parameter int W = 1) (
	// Clock and control
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q_r
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] q_nxt;

	// First stage feeds only the second stage
	always_comb begin
		s1_nxt = ce ? d : s1_r;
		q_nxt = ce ? s1_r : q_r;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_r <= '0;
			q_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			q_r <= q_nxt;
		end
	end
endmodule

// ===== core/pfs_pin_mux.sv
// Pin function multiplexer with AXI4-Lite configuration registers
`timescale 1ns/100ps
`include "pfs_defines.svh"
module pfs_pin_mux (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Port A / host data pins
	input wire logic [7:0] pa_pin_in,
	output logic [7:0] pa_pin_out,
	output logic [7:0] pa_pin_oe,
	// Channel B / host control pins
	input wire logic [6:0] cb_pin_in,
	output logic [6:0] cb_pin_out,
	output logic [6:0] cb_pin_oe,
	// Three-function status pins
	input wire logic [2:0] hs_pin_in,
	output logic [2:0] hs_pin_out,
	output logic [2:0] hs_pin_oe,
	// Channel A / port C pins, index is port C bit, bit 2 is the write strobe pin
	input wire logic [5:0] pc_pin_in,
	output logic [5:0] pc_pin_out,
	output logic [5:0] pc_pin_oe,
	// Daisy-chain pin, read strobe pin, interrupt pins
	input wire logic daisy_pin_in,
	output logic daisy_pin_out,
	output logic daisy_pin_oe,
	output logic mrd_pin_out,
	input wire logic [1:0] int_pin_in,
	// Internal: parallel port A
	input wire logic [7:0] par_port_a_out,
	input wire logic [7:0] par_port_a_oe,
	output logic [7:0] par_port_a_in,
	// Internal: host bus
	input wire logic [7:0] host_data_out,
	input wire logic [7:0] host_data_oe,
	output logic [7:0] host_data_in,
	output logic [6:0] host_ctl_in,
	input wire logic [2:0] host_stat,
	// Internal: serial channel B
	input wire logic [6:0] chan_b_out,
	input wire logic [6:0] chan_b_oe,
	output logic [6:0] chan_b_in,
	input wire logic [2:0] chan_b_req_out,
	input wire logic [2:0] chan_b_req_oe,
	input wire logic [2:0] hs_first_out,
	input wire logic [2:0] hs_first_oe,
	output logic [2:0] hs_func_in,
	// Internal: port C and channel A
	input wire logic [5:0] par_port_c_out,
	input wire logic [5:0] par_port_c_oe,
	output logic [7:0] par_port_c_in,
	input wire logic [5:0] chan_a_out,
	input wire logic [5:0] chan_a_oe,
	// Internal: strobes and daisy chain
	input wire logic memory_write_strobe_n,
	input wire logic memory_read_strobe_n,
	input wire logic memory_request_strobe_n,
	input wire logic daisy_chain_enable_out,
	output logic daisy_chain_enable_in
);
	import pfs_pkg::*;

	logic [7:0] cfg_r, cfg_nxt, mux_r, mux_nxt;
	logic [`PFS_SYNC_W-1:0] sy;
	logic [7:0] s_pa;
	logic [6:0] s_cb;
	logic [2:0] s_hs;
	logic [5:0] s_pc;
	logic s_dy;
	logic [1:0] s_int;
	logic host, hstat, hsecond, portc, daisy_o, memreq;
	pfs_bus_st_t wst_r, wst_nxt, rdst_r, rdst_nxt;
	logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0] bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	logic [7:0] pa_out_nxt, pa_oe_nxt, pa_in_nxt, hd_in_nxt;
	logic [6:0] cb_out_nxt, cb_oe_nxt, cb_in_nxt, hc_in_nxt;
	logic [2:0] hs_out_nxt, hs_oe_nxt, hs_in_nxt;
	logic [5:0] pc_out_nxt, pc_oe_nxt;
	logic [7:0] pcin_nxt;
	logic dy_out_nxt, dy_oe_nxt, dy_in_nxt, mrd_nxt;

	// Two-input steering, used for every shared pin
	function automatic logic pick(input logic s, input logic a, input logic b);
		pick = s ? a : b;
	endfunction

	// Address decode shared by read and write paths
	function automatic pfs_reg_t dec(input logic [7:0] a);
		case (a)
			`PFS_OFS_SYSCFG: dec = pfs_reg_cfg;
			`PFS_OFS_PINMUX: dec = pfs_reg_mux;
			`PFS_OFS_STATUS: dec = pfs_reg_stat;
			default: dec = pfs_reg_none;
		endcase
	endfunction

	// All pin inputs cross in through two flops
	pfs_sync #(.W(`PFS_SYNC_W)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.d({int_pin_in, daisy_pin_in, pc_pin_in, hs_pin_in, cb_pin_in, pa_pin_in}),
		.q_r(sy)
	);
	assign {s_int, s_dy, s_pc, s_hs, s_cb, s_pa} = sy;

	// Selections decoded from the two configuration registers
	assign host = cfg_r[`PFS_CFG_HOST];
	assign hstat = cfg_r[`PFS_CFG_HOST] & cfg_r[`PFS_CFG_HSTAT];
	assign hsecond = cfg_r[`PFS_CFG_HSTAT] & ~cfg_r[`PFS_CFG_HOST];
	assign portc = cfg_r[`PFS_CFG_PORTC];
	assign daisy_o = mux_r[`PFS_MUX_DAISY];
	assign memreq = mux_r[`PFS_MUX_MEMSTB];

	// Write channel: address and data taken together, then one response
	always_comb begin
		wst_nxt = wst_r;
		awready_nxt = s_axi_awready;
		wready_nxt = s_axi_wready;
		bvalid_nxt = s_axi_bvalid;
		bresp_nxt = s_axi_bresp;
		cfg_nxt = cfg_r;
		mux_nxt = mux_r;
		case (wst_r)
			pfs_idle: begin
				if (s_axi_awvalid && s_axi_wvalid) begin
					awready_nxt = 1'b1;
					wready_nxt = 1'b1;
					wst_nxt = pfs_take;
				end
			end
			pfs_take: begin
				awready_nxt = 1'b0;
				wready_nxt = 1'b0;
				bvalid_nxt = 1'b1;
				bresp_nxt = `PFS_RESP_OKAY;
				wst_nxt = pfs_resp;
				case (dec(s_axi_awaddr))
					pfs_reg_cfg: if (s_axi_wstrb[`PFS_STRB_LANE]) cfg_nxt = s_axi_wdata[7:0];
					pfs_reg_mux: if (s_axi_wstrb[`PFS_STRB_LANE]) mux_nxt = s_axi_wdata[7:0];
					pfs_reg_stat: ; // Read-only, write ignored
					default: bresp_nxt = `PFS_RESP_SLVERR;
				endcase
			end
			pfs_resp: begin
				if (s_axi_bready) begin
					bvalid_nxt = 1'b0;
					wst_nxt = pfs_idle;
				end
			end
			default: wst_nxt = pfs_idle;
		endcase
	end

	// Read channel: data captured in the cycle the address is taken
	always_comb begin
		rdst_nxt = rdst_r;
		arready_nxt = s_axi_arready;
		rvalid_nxt = s_axi_rvalid;
		rdata_nxt = s_axi_rdata;
		rresp_nxt = s_axi_rresp;
		case (rdst_r)
			pfs_idle: begin
				if (s_axi_arvalid) begin
					arready_nxt = 1'b1;
					rdst_nxt = pfs_take;
				end
			end
			pfs_take: begin
				arready_nxt = 1'b0;
				rvalid_nxt = 1'b1;
				rresp_nxt = `PFS_RESP_OKAY;
				rdst_nxt = pfs_resp;
				case (dec(s_axi_araddr))
					pfs_reg_cfg: rdata_nxt = {`PFS_ZERO_HI, cfg_r};
					pfs_reg_mux: rdata_nxt = {`PFS_ZERO_HI, mux_r};
					pfs_reg_stat: rdata_nxt = {`PFS_ZERO_HI, par_port_c_in}; // see R7
					default: begin
						rdata_nxt = '0;
						rresp_nxt = `PFS_RESP_SLVERR;
					end
				endcase
			end
			pfs_resp: begin
				if (s_axi_rready) begin
					rvalid_nxt = 1'b0;
					rdst_nxt = pfs_idle;
				end
			end
			default: rdst_nxt = pfs_idle;
		endcase
	end

	// Pin steering; registered so pins never glitch on a config write
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pa_out_nxt[i] = pick(host, host_data_out[i], par_port_a_out[i]); // see R1
			pa_oe_nxt[i] = pick(host, host_data_oe[i], par_port_a_oe[i]); // see R1
		end
		// Host control pins are inputs only in host mode
		for (int i = 0; i < 7; i++) begin
			cb_out_nxt[i] = pick(host, 1'b1, chan_b_out[i]); // see R1
			cb_oe_nxt[i] = pick(host, 1'b0, chan_b_oe[i]); // see R1
		end
		for (int i = 0; i < 3; i++) begin
			hs_out_nxt[i] = hstat ? host_stat[i] : pick(hsecond, chan_b_req_out[i], hs_first_out[i]); // see R2
			hs_oe_nxt[i] = hstat | pick(hsecond, chan_b_req_oe[i], hs_first_oe[i]); // see R2
		end
		for (int i = 0; i < 6; i++) begin
			pc_out_nxt[i] = pick(portc, par_port_c_out[i], chan_a_out[i]); // see R3
			pc_oe_nxt[i] = pick(portc, par_port_c_oe[i], chan_a_oe[i]); // see R3
		end
		// Write strobe pin: mux bit first, then config bit 7
		pc_out_nxt[2] = pick(memreq, pick(portc, par_port_c_out[2], chan_a_out[2]), memory_write_strobe_n); // see R4 R8
		pc_oe_nxt[2] = pick(memreq, pick(portc, par_port_c_oe[2], chan_a_oe[2]), 1'b1); // see R4 R8
		dy_out_nxt = pick(daisy_o, daisy_chain_enable_out, 1'b1); // see R5
		dy_oe_nxt = daisy_o; // see R5
		mrd_nxt = pick(memreq, memory_request_strobe_n, memory_read_strobe_n); // see R6
		// Inputs back to the internal functions
		pa_in_nxt = s_pa;
		hd_in_nxt = s_pa;
		cb_in_nxt = s_cb;
		hc_in_nxt = host ? s_cb : 7'h7f; // Idle-high when host bus is off
		hs_in_nxt = s_hs;
		pcin_nxt = {s_int[1], s_int[0], s_pc}; // see R7
		dy_in_nxt = daisy_o ? 1'b1 : s_dy; // Enabled when the pin is an output
	end

	// Register bank; clock enable freezes everything
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_r <= `PFS_CFG_RST; // see R9
			mux_r <= `PFS_MUX_RST; // see R9
			wst_r <= pfs_idle;
			rdst_r <= pfs_idle;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PFS_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `PFS_RESP_OKAY;
			pa_pin_out <= '1;
			pa_pin_oe <= '0;
			cb_pin_out <= '1;
			cb_pin_oe <= '0;
			hs_pin_out <= '1;
			hs_pin_oe <= '0;
			pc_pin_out <= '1;
			pc_pin_oe <= `PFS_PC_OE_RST; // see R9
			daisy_pin_out <= 1'b1;
			daisy_pin_oe <= 1'b0;
			mrd_pin_out <= 1'b1;
			par_port_a_in <= '0;
			host_data_in <= '0;
			chan_b_in <= '0;
			host_ctl_in <= '1;
			hs_func_in <= '0;
			par_port_c_in <= '0;
			daisy_chain_enable_in <= 1'b1;
		end else if (ce) begin
			cfg_r <= cfg_nxt;
			mux_r <= mux_nxt;
			wst_r <= wst_nxt;
			rdst_r <= rdst_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready <= wready_nxt;
			s_axi_bvalid <= bvalid_nxt;
			s_axi_bresp <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid <= rvalid_nxt;
			s_axi_rdata <= rdata_nxt;
			s_axi_rresp <= rresp_nxt;
			pa_pin_out <= pa_out_nxt;
			pa_pin_oe <= pa_oe_nxt;
			cb_pin_out <= cb_out_nxt;
			cb_pin_oe <= cb_oe_nxt;
			hs_pin_out <= hs_out_nxt;
			hs_pin_oe <= hs_oe_nxt;
			pc_pin_out <= pc_out_nxt;
			pc_pin_oe <= pc_oe_nxt;
			daisy_pin_out <= dy_out_nxt;
			daisy_pin_oe <= dy_oe_nxt;
			mrd_pin_out <= mrd_nxt;
			par_port_a_in <= pa_in_nxt;
			host_data_in <= hd_in_nxt;
			chan_b_in <= cb_in_nxt;
			host_ctl_in <= hc_in_nxt;
			hs_func_in <= hs_in_nxt;
			par_port_c_in <= pcin_nxt;
			daisy_chain_enable_in <= dy_in_nxt;
		end
	end

	// Checks on the steering
	default clocking cb_chk @(posedge mclk); endclocking
	default disable iff (rst);

	a_host_data_bus: assert property (ce && host |=> // see R1
		pa_pin_out == $past(host_data_out) && cb_pin_oe == 7'h00)
		else $error("port A pins not on host bus");
	a_host_stat_pins: assert property (ce && hstat |=> // see R2
		hs_pin_out == $past(host_stat) && hs_pin_oe == 3'h7)
		else $error("status pins not on host function");
	a_port_c_pins: assert property (ce && portc |=> // see R3
		pc_pin_out[5:3] == $past(par_port_c_out[5:3]) && pc_pin_oe[1:0] == $past(par_port_c_oe[1:0]))
		else $error("channel A pins not on port C");
	a_rts_on_strobe: assert property (ce && memreq && !portc |=> // see R4
		pc_pin_out[2] == $past(chan_a_out[2]) && pc_pin_oe[2] == $past(chan_a_oe[2]))
		else $error("write strobe pin not on RTS");
	a_daisy_dir: assert property (ce && !daisy_o |=> !daisy_pin_oe) // see R5
		else $error("daisy pin driven while input");
	a_mem_req_pin: assert property (ce && memreq |=> mrd_pin_out == $past(memory_request_strobe_n)) // see R6
		else $error("read strobe pin not on request strobe");
	// Reset edge excluded: flops take reset values there, not the sampled pins
	a_int_pins_read: assert property ((ce && !rst) [*3] |=> par_port_c_in[7:6] == $past(int_pin_in, 3)) // see R7
		else $error("port C 7:6 do not follow interrupt pins");
	a_write_strobe: assert property (ce && !rst && !memreq |=> // see R8
		pc_pin_out[2] == $past(memory_write_strobe_n) && pc_pin_oe[2])
		else $error("write strobe pin lost its strobe");
	a_reset_first: assert property ($fell(rst) |-> cfg_r == `PFS_CFG_RST && mux_r == `PFS_MUX_RST) // see R9
		else $error("selection not at first function after reset");

	c_host_mode: cover property (ce && hstat ##1 s_axi_rvalid);
	c_port_c_rts: cover property (ce && memreq && !portc);
	c_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == `PFS_RESP_SLVERR);
endmodule

// ===== dv/pfs_far_side.sv
// Far-side pad model: resolves each shared pad from design and outside drivers
`timescale 1ns/100ps
module pfs_far_side (
	// Port A / host data pads
	input wire logic [7:0] pa_pin_out,
	input wire logic [7:0] pa_pin_oe,
	input wire logic [7:0] pa_ext,
	output logic [7:0] pa_pin_in,
	// Channel B / host control pads
	input wire logic [6:0] cb_pin_out,
	input wire logic [6:0] cb_pin_oe,
	input wire logic [6:0] cb_ext,
	output logic [6:0] cb_pin_in,
	// Status pads
	input wire logic [2:0] hs_pin_out,
	input wire logic [2:0] hs_pin_oe,
	input wire logic [2:0] hs_ext,
	output logic [2:0] hs_pin_in,
	// Channel A / port C pads
	input wire logic [5:0] pc_pin_out,
	input wire logic [5:0] pc_pin_oe,
	input wire logic [5:0] pc_ext,
	output logic [5:0] pc_pin_in,
	// Daisy pad
	input wire logic daisy_pin_out,
	input wire logic daisy_pin_oe,
	input wire logic daisy_ext,
	output logic daisy_pin_in
);
	// Outside parties drive only bits the design has let go, so no fight is modelled
	assign pa_pin_in = (pa_pin_out & pa_pin_oe) | (pa_ext & ~pa_pin_oe);
	assign cb_pin_in = (cb_pin_out & cb_pin_oe) | (cb_ext & ~cb_pin_oe);
	assign hs_pin_in = (hs_pin_out & hs_pin_oe) | (hs_ext & ~hs_pin_oe);
	assign pc_pin_in = (pc_pin_out & pc_pin_oe) | (pc_ext & ~pc_pin_oe);
	assign daisy_pin_in = daisy_pin_oe ? daisy_pin_out : daisy_ext;
endmodule

// ===== dv/test_pin_function_select.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_pin_function_select;
	import pfs_pkg::*;
	logic mclk, rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic daisy_pin_in, daisy_pin_out, daisy_pin_oe, mrd_pin_out, daisy_ext;
	logic memory_write_strobe_n, memory_read_strobe_n, memory_request_strobe_n;
	logic daisy_chain_enable_out, daisy_chain_enable_in;
	logic [1:0] s_axi_bresp, s_axi_rresp, int_pin_in, resp_q;
	logic [3:0] s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdata_q;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pa_pin_in, pa_pin_out, pa_pin_oe, pa_ext;
	logic [7:0] par_port_a_out, par_port_a_oe, par_port_a_in, par_port_c_in;
	logic [7:0] host_data_out, host_data_oe, host_data_in;
	logic [6:0] cb_pin_in, cb_pin_out, cb_pin_oe, cb_ext, host_ctl_in, chan_b_out, chan_b_oe;
	logic [6:0] chan_b_in;
	logic [2:0] hs_pin_in, hs_pin_out, hs_pin_oe, hs_ext, host_stat, chan_b_req_out;
	logic [2:0] chan_b_req_oe, hs_first_out, hs_first_oe, hs_func_in;
	logic [5:0] pc_pin_in, pc_pin_out, pc_pin_oe, pc_ext, par_port_c_out, par_port_c_oe;
	logic [5:0] chan_a_out, chan_a_oe;
	int num_errors = 0;
	int n_checks = 0;

	pfs_pin_mux pfs_pin_mux_i (.mclk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pa_pin_in, .pa_pin_out, .pa_pin_oe,
		.cb_pin_in, .cb_pin_out, .cb_pin_oe, .hs_pin_in, .hs_pin_out, .hs_pin_oe, .pc_pin_in,
		.pc_pin_out, .pc_pin_oe, .daisy_pin_in, .daisy_pin_out, .daisy_pin_oe, .mrd_pin_out,
		.int_pin_in, .par_port_a_out, .par_port_a_oe, .par_port_a_in, .host_data_out,
		.host_data_oe, .host_data_in, .host_ctl_in, .host_stat, .chan_b_out, .chan_b_oe,
		.chan_b_in, .chan_b_req_out, .chan_b_req_oe, .hs_first_out, .hs_first_oe, .hs_func_in,
		.par_port_c_out, .par_port_c_oe, .par_port_c_in, .chan_a_out, .chan_a_oe,
		.memory_write_strobe_n, .memory_read_strobe_n, .memory_request_strobe_n,
		.daisy_chain_enable_out, .daisy_chain_enable_in);

	pfs_far_side pfs_far_side_i (.pa_pin_out, .pa_pin_oe, .pa_ext, .pa_pin_in, .cb_pin_out,
		.cb_pin_oe, .cb_ext, .cb_pin_in, .hs_pin_out, .hs_pin_oe, .hs_ext, .hs_pin_in,
		.pc_pin_out, .pc_pin_oe, .pc_ext, .pc_pin_in, .daisy_pin_out, .daisy_pin_oe,
		.daisy_ext, .daisy_pin_in);

	// Free-running 250 MHz clock
	always #2 mclk = ~mclk;

	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Pins follow config one cycle late and inputs three edges late; six covers both
	task automatic settle;
		repeat (6) @(posedge mclk);
	endtask

	// Write: address and data offered together, each dropped when its ready is seen
	// Loop on a local flag: the bready just scheduled is not yet visible here
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit done;
		done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!done) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				resp_q = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	// Read: rready held until the answer is sampled
	task automatic rd(input logic [7:0] a);
		bit done;
		done = 1'b0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		while (!done) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rdata_q = s_axi_rdata;
				resp_q = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic t_reset;
		`CHK(pa_pin_out, par_port_a_out)
		`CHK(hs_pin_out, hs_first_out)
		`CHK({pc_pin_oe[2], pc_pin_out[2]}, {1'b1, memory_write_strobe_n})
		`CHK({daisy_pin_oe, mrd_pin_out}, {1'b0, memory_read_strobe_n})
		`CHK(host_ctl_in, 7'h7F)
		`CHK({pa_pin_oe, par_port_a_in}, {8'hFF, 8'h3C})
		`CHK({cb_pin_out, chan_b_in, hs_pin_oe, hs_func_in}, {7'h2B, 7'h2B, 3'h7, 3'h5})
		rd(8'h00);
		`CHK(rdata_q, 32'h0000_0000)
		rd(8'h04);
		`CHK(rdata_q, 32'h0000_0000)
		$display("reset test done");
	endtask

	task automatic t_host;
		wr(8'h00, 32'h0000_0002);
		settle();
		`CHK(pa_pin_out, host_data_out)
		`CHK(cb_pin_oe, 7'h00)
		`CHK(host_ctl_in, cb_ext)
		`CHK({pa_pin_oe, host_data_in, cb_pin_out}, {8'h0F, 8'h95, 7'h7F})
		`CHK(hs_pin_out, hs_first_out)
		wr(8'h00, 32'h0000_0006);
		settle();
		`CHK(hs_pin_out, host_stat)
		rd(8'h00);
		`CHK(rdata_q, 32'h0000_0006)
		wr(8'h00, 32'h0000_0004);
		settle();
		`CHK(hs_pin_out, chan_b_req_out)
		`CHK({pa_pin_out, host_ctl_in}, {par_port_a_out, 7'h7F})
		$display("host test done");
	endtask

	task automatic t_portc;
		wr(8'h04, 32'h0000_0008);
		wr(8'h00, 32'h0000_0080);
		settle();
		`CHK({pc_pin_oe, pc_pin_out}, {par_port_c_oe, par_port_c_out})
		`CHK(mrd_pin_out, memory_request_strobe_n)
		wr(8'h00, 32'h0000_0000);
		settle();
		`CHK(pc_pin_out, chan_a_out)
		wr(8'h04, 32'h0000_0000);
		settle();
		`CHK(pc_pin_out[2], memory_write_strobe_n)
		`CHK(mrd_pin_out, memory_read_strobe_n)
		$display("port c test done");
	endtask

	task automatic t_daisy;
		wr(8'h04, 32'h0000_0004);
		settle();
		`CHK({daisy_pin_oe, daisy_pin_out}, {1'b1, daisy_chain_enable_out})
		`CHK(daisy_chain_enable_in, 1'b1)
		wr(8'h04, 32'h0000_0000);
		settle();
		`CHK({daisy_pin_oe, daisy_chain_enable_in}, {1'b0, daisy_ext})
		$display("daisy test done");
	endtask

	task automatic t_intpins;
		int_pin_in <= 2'b01;
		settle();
		`CHK(par_port_c_in[7:6], 2'b01)
		int_pin_in <= 2'b10;
		settle();
		rd(8'h08);
		`CHK(rdata_q[7:6], 2'b10)
		`CHK(par_port_c_in[7:6], 2'b10)
		$display("interrupt pin test done");
	endtask

	task automatic t_bus;
		wr(8'h0C, 32'h0000_00FF);
		`CHK(resp_q, 2'b10)
		rd(8'h0C);
		`CHK({resp_q, rdata_q}, {2'b10, 32'h0000_0000})
		// Lane 0 strobe off: the write must not land
		s_axi_wstrb <= 4'h0;
		wr(8'h04, 32'h0000_00FF);
		s_axi_wstrb <= 4'hF;
		wr(8'h08, 32'h0000_00FF);
		`CHK(resp_q, 2'b00)
		rd(8'h04);
		`CHK({resp_q, rdata_q}, {2'b00, 32'h0000_0000})
		$display("bus test done");
	endtask

	// Enable low must freeze the pins; a mid-run reset restores first functions
	task automatic t_hold;
		wr(8'h00, 32'h0000_0002);
		settle();
		ce <= 1'b0;
		host_data_out <= 8'h5A;
		settle();
		`CHK(pa_pin_out, 8'hA5)
		ce <= 1'b1;
		settle();
		`CHK(pa_pin_out, 8'h5A)
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		settle();
		`CHK({pa_pin_out, host_ctl_in}, {8'h3C, 7'h7F})
		rd(8'h00);
		`CHK(rdata_q, 32'h0000_0000)
		$display("hold and reset test done");
	endtask

	// Distinct patterns per function so a wrong steering choice shows
	initial begin
		mclk = 1'b0;
		rst <= 1'b1;
		ce <= 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {16'h0000, 32'h0000_0000, 4'hF};
		{par_port_a_out, par_port_a_oe, host_data_out, host_data_oe} <= 32'h3CFF_A50F;
		{host_stat, chan_b_req_out, chan_b_req_oe, hs_first_out, hs_first_oe} <= 15'h2DEF;
		{chan_b_out, chan_b_oe, par_port_c_out, par_port_c_oe} <= 26'h15F_D57F;
		{chan_a_out, chan_a_oe, int_pin_in} <= 14'h2EFE;
		{memory_write_strobe_n, memory_read_strobe_n, memory_request_strobe_n} <= 3'b010;
		daisy_chain_enable_out <= 1'b0;
		{pa_ext, cb_ext, hs_ext, pc_ext, daisy_ext} <= 25'h12D_5A16;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		settle();
		t_reset();
		t_host();
		t_portc();
		t_daisy();
		t_intpins();
		t_bus();
		t_hold();
		wrap_up();
	end

	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		wrap_up();
	end
endmodule
